// [rtl/pbg_pkg.sv]
`default_nettype none
package pbg_pkg;
  localparam int unsigned PBG_WIDTH = 8;
  localparam int unsigned PBG_CHG_LO = 4;
  localparam int unsigned PBG_CHG_N = 4;
  localparam int unsigned PBG_SEG_LO = 1;
  localparam int unsigned PBG_SEG_N = 4;
  localparam int unsigned PBG_EXT_N = 4;
  localparam int unsigned PBG_PROG_CLK_PIN = 6;
  localparam int unsigned PBG_PROG_DAT_PIN = 7;

  localparam logic [7:0] PBG_ADDR_PORT = 8'h00;
  localparam logic [7:0] PBG_ADDR_LATCH = 8'h04;
  localparam logic [7:0] PBG_ADDR_DIR = 8'h08;
  localparam logic [7:0] PBG_ADDR_MAIN = 8'h0C;
  localparam logic [7:0] PBG_ADDR_EDGES = 8'h10;
  localparam logic [7:0] PBG_ADDR_EXT = 8'h14;
  localparam logic [7:0] PBG_ADDR_SEG = 8'h18;
  localparam logic [7:0] PBG_ADDR_DEBUG = 8'h1C;
  localparam logic [7:0] PBG_ADDR_PORT_QUIET = 8'h20;

  localparam int unsigned PBG_FLAG_BIT = 0;
  localparam int unsigned PBG_ENABLE_BIT = 3;
  localparam int unsigned PBG_PRIO_BIT = 0;
  localparam int unsigned PBG_PULLUP_N_BIT = 7;
  localparam int unsigned PBG_DEBUG_EN_BIT = 0;

  localparam logic [7:0] PBG_RST_LATCH = 8'h00;
  localparam logic [7:0] PBG_RST_DIR = 8'hFF;
  localparam logic [7:0] PBG_RST_MAIN = 8'h00;
  localparam logic [7:0] PBG_RST_EDGES = 8'hFF;
  localparam logic [7:0] PBG_RST_EXT = 8'hC0;
  localparam logic [7:0] PBG_RST_SEG = 8'h00;
  localparam logic PBG_RST_DEBUG = 1'b0;
endpackage
`default_nettype wire

// [rtl/pbg_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pbg_sync #(
  parameter int unsigned W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// [rtl/pbg_change.sv]
`timescale 1ns/1ps
`default_nettype none
module pbg_change #(
  parameter int unsigned N = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] level,
  input wire logic [N-1:0] take_part,
  input wire logic refresh,
  output logic mismatch
);
  logic [N-1:0] snapshot;

  // copy of the levels seen at the last port access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snapshot <= '0;
    end else if (refresh) begin
      snapshot <= level;
    end
  end

  assign mismatch = |((level ^ snapshot) & take_part);
endmodule
`default_nettype wire

// [rtl/pbg_port.sv]
// Notes on behaviour
// - eight pins, each input or output
// - direction one: driver off, pin input
// - direction zero: latch drives the pin
// - latch register reads back latch, not pins
// - bit 7 cleared enables all pull-ups
// - output pins never get pull-up
// - pull-ups off after power-on reset
// - upper four input pins detect changes
// - compare inputs with last-read copy
// - ORed mismatches set flag bit 0
// - port change can wake the device
// - port access refreshes copy, quiet read excepted
// - persisting mismatch keeps setting the flag
// - segment enable removes digital output pins 1-4
// - pins 1-4 are segments 8-11
// - input pins 0-3 feed external interrupts
// - debug enable takes over pins 6, 7
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pbg_port
  import pbg_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PBG_WIDTH-1:0] pin_in,
  output logic [PBG_WIDTH-1:0] pin_out,
  output logic [PBG_WIDTH-1:0] pin_oe_n,
  output logic [PBG_WIDTH-1:0] pullup_en,
  output logic [PBG_SEG_N-1:0] lcd_seg_active,
  output logic [PBG_EXT_N-1:0] ext_irq_in,
  output logic prog_serial_clock,
  output logic prog_serial_data_in,
  input wire logic prog_data_drive,
  input wire logic prog_data_drive_en,
  output logic port_change_irq,
  output logic port_change_high_prio,
  output logic wake_req
);
  logic [PBG_WIDTH-1:0] port_output_latch;
  logic [PBG_WIDTH-1:0] port_direction;
  logic [7:0] interrupt_control_main;
  logic [7:0] interrupt_control_edges;
  logic [7:0] interrupt_control_ext;
  logic [7:0] lcd_segment_enable_low;
  logic in_circuit_debug;
  logic [PBG_WIDTH-1:0] pin_sync;
  logic mismatch;
  logic setup;
  logic acc;
  logic wr;
  logic port_touch;
  logic [PBG_WIDTH-1:0] seg_pin;
  logic [PBG_WIDTH-1:0] prog_pin;
  logic [PBG_CHG_N-1:0] take_part;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic [PBG_WIDTH-1:0] next_pin_out;
  logic [PBG_WIDTH-1:0] next_pin_oe_n;
  logic [PBG_WIDTH-1:0] next_pullup_en;
  logic next_flag;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;

  // quiet alias leaves the copy alone
  assign port_touch = acc && hit(paddr, PBG_ADDR_PORT);

  pbg_sync #(
    .W(PBG_WIDTH)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_in),
    .q(pin_sync)
  );

  // segment enables 8..11 sit in bits 3..0
  always_comb begin
    seg_pin = '0;
    seg_pin[PBG_SEG_LO +: PBG_SEG_N] = lcd_segment_enable_low[PBG_SEG_N-1:0];
  end

  always_comb begin
    prog_pin = '0;
    prog_pin[PBG_PROG_CLK_PIN] = in_circuit_debug;
    prog_pin[PBG_PROG_DAT_PIN] = in_circuit_debug;
  end

  // only upper input pins, not taken by debug
  assign take_part = port_direction[PBG_CHG_LO +: PBG_CHG_N]
    & ~prog_pin[PBG_CHG_LO +: PBG_CHG_N];

  pbg_change #(
    .N(PBG_CHG_N)
  ) u_change (
    .pclk(pclk),
    .presetn(presetn),
    .level(pin_sync[PBG_CHG_LO +: PBG_CHG_N]),
    .take_part(take_part),
    .refresh(port_touch),
    .mismatch(mismatch)
  );

  // latch written from either port or latch address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_output_latch <= PBG_RST_LATCH;
    end else if (wr && (hit(paddr, PBG_ADDR_PORT) || hit(paddr, PBG_ADDR_LATCH))) begin
      port_output_latch <= pwdata[PBG_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_direction <= PBG_RST_DIR;
    end else if (wr && hit(paddr, PBG_ADDR_DIR)) begin
      port_direction <= pwdata[PBG_WIDTH-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_edges <= PBG_RST_EDGES;
      interrupt_control_ext <= PBG_RST_EXT;
      lcd_segment_enable_low <= PBG_RST_SEG;
      in_circuit_debug <= PBG_RST_DEBUG;
    end else if (wr) begin
      if (hit(paddr, PBG_ADDR_EDGES)) begin
        interrupt_control_edges <= pwdata[7:0];
      end
      if (hit(paddr, PBG_ADDR_EXT)) begin
        interrupt_control_ext <= pwdata[7:0];
      end
      if (hit(paddr, PBG_ADDR_SEG)) begin
        lcd_segment_enable_low <= pwdata[7:0];
      end
      if (hit(paddr, PBG_ADDR_DEBUG)) begin
        in_circuit_debug <= pwdata[PBG_DEBUG_EN_BIT];
      end
    end
  end

  // mismatch sets the flag and beats a clear
  always_comb begin
    next_flag = interrupt_control_main[PBG_FLAG_BIT];
    if (wr && hit(paddr, PBG_ADDR_MAIN)) begin
      next_flag = pwdata[PBG_FLAG_BIT];
    end
    if (mismatch) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_control_main <= PBG_RST_MAIN;
    end else begin
      if (wr && hit(paddr, PBG_ADDR_MAIN)) begin
        interrupt_control_main <= pwdata[7:0];
      end
      interrupt_control_main[PBG_FLAG_BIT] <= next_flag;
    end
  end

  // register read mux
  always_comb begin
    next_prdata = '0;
    next_pslverr = 1'b0;
    case (paddr)
      PBG_ADDR_PORT, PBG_ADDR_PORT_QUIET: next_prdata[PBG_WIDTH-1:0] = pin_sync;
      PBG_ADDR_LATCH: next_prdata[PBG_WIDTH-1:0] = port_output_latch;
      PBG_ADDR_DIR: next_prdata[PBG_WIDTH-1:0] = port_direction;
      PBG_ADDR_MAIN: next_prdata[7:0] = interrupt_control_main;
      PBG_ADDR_EDGES: next_prdata[7:0] = interrupt_control_edges;
      PBG_ADDR_EXT: next_prdata[7:0] = interrupt_control_ext;
      PBG_ADDR_SEG: next_prdata[7:0] = lcd_segment_enable_low;
      PBG_ADDR_DEBUG: next_prdata[PBG_DEBUG_EN_BIT] = in_circuit_debug;
      default: next_pslverr = 1'b1;
    endcase
  end

  // answer is prepared during setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (setup) begin
      pready <= 1'b1;
      prdata <= pwrite ? '0 : next_prdata;
      pslverr <= next_pslverr;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // pin drivers
  always_comb begin
    for (int i = 0; i < PBG_WIDTH; i++) begin
      next_pin_oe_n[i] = port_direction[i];
      next_pin_out[i] = port_output_latch[i];
      next_pullup_en[i] = port_direction[i]
        && !interrupt_control_edges[PBG_PULLUP_N_BIT];
      if (seg_pin[i] || prog_pin[i]) begin
        next_pin_oe_n[i] = 1'b1;
        next_pin_out[i] = 1'b0;
        next_pullup_en[i] = 1'b0;
      end
    end
    // serial data line driven by debug logic
    if (in_circuit_debug) begin
      next_pin_oe_n[PBG_PROG_DAT_PIN] = !prog_data_drive_en;
      next_pin_out[PBG_PROG_DAT_PIN] = prog_data_drive;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_n <= '1;
      pin_out <= '0;
      pullup_en <= '0;
      lcd_seg_active <= '0;
    end else begin
      pin_oe_n <= next_pin_oe_n;
      pin_out <= next_pin_out;
      pullup_en <= next_pullup_en;
      lcd_seg_active <= lcd_segment_enable_low[PBG_SEG_N-1:0];
    end
  end

  // side functions of the input pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_in <= '0;
      prog_serial_clock <= 1'b0;
      prog_serial_data_in <= 1'b0;
    end else begin
      ext_irq_in <= pin_sync[PBG_EXT_N-1:0] & port_direction[PBG_EXT_N-1:0];
      // clock and data inputs for debug
      prog_serial_clock <= in_circuit_debug && pin_sync[PBG_PROG_CLK_PIN];
      prog_serial_data_in <= in_circuit_debug && pin_sync[PBG_PROG_DAT_PIN];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_change_irq <= 1'b0;
      port_change_high_prio <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      // gated by enable, priority from its bit
      port_change_irq <= interrupt_control_main[PBG_FLAG_BIT]
        && interrupt_control_main[PBG_ENABLE_BIT];
      port_change_high_prio <= interrupt_control_edges[PBG_PRIO_BIT];
      // wake on a pending enabled change
      wake_req <= interrupt_control_main[PBG_FLAG_BIT]
        && interrupt_control_main[PBG_ENABLE_BIT];
    end
  end

  sequence s_port_access;
    psel && penable && pready && (paddr == PBG_ADDR_PORT);
  endsequence

  sequence s_latch_read_setup;
    psel && !penable && !pwrite && (paddr == PBG_ADDR_LATCH);
  endsequence

  AST_DIR_INPUT_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
    port_direction[5] |=> pin_oe_n[5])
    else $error("input pin is driven");

  AST_DIR_OUTPUT_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
    (!port_direction[5] && !in_circuit_debug) |=>
      (!pin_oe_n[5] && pin_out[5] == $past(port_output_latch[5])))
    else $error("output pin not driven from latch");

  AST_LATCH_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
    s_latch_read_setup |=> prdata[PBG_WIDTH-1:0] == $past(port_output_latch))
    else $error("latch read returned wrong value");

  AST_PULLUP_OFF_OUTPUT: assert property (@(posedge pclk) disable iff (!presetn)
    !port_direction[0] |=> !pullup_en[0])
    else $error("pull-up on an output pin");

  AST_PULLUP_NEEDS_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(interrupt_control_edges[PBG_PULLUP_N_BIT]) |->
      $past(wr && paddr == PBG_ADDR_EDGES))
    else $error("pull-ups enabled without a write");

  AST_OUTPUTS_EXCLUDED: assert property (@(posedge pclk) disable iff (!presetn)
    (port_direction[7:4] == 4'h0) |-> !mismatch)
    else $error("output pin caused a mismatch");

  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    mismatch |=> interrupt_control_main[PBG_FLAG_BIT])
    else $error("mismatch did not set the flag");

  AST_REFRESH_ENDS: assert property (@(posedge pclk) disable iff (!presetn)
    s_port_access ##1 $stable(pin_sync[7:4]) |-> !mismatch)
    else $error("port access did not end the mismatch");

  AST_IRQ_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    port_change_irq |-> $past(interrupt_control_main[PBG_ENABLE_BIT]))
    else $error("interrupt without enable");

  AST_PROG_TAKEOVER: assert property (@(posedge pclk) disable iff (!presetn)
    in_circuit_debug |=> pin_oe_n[6] && !pullup_en[7])
    else $error("debug pins not taken over");
endmodule
`default_nettype wire

// [test/pbg_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pbg_pins_model
  import pbg_pkg::*;
(
  input wire logic pclk,
  input wire logic [PBG_WIDTH-1:0] pin_out,
  input wire logic [PBG_WIDTH-1:0] pin_oe_n,
  input wire logic [PBG_WIDTH-1:0] pullup_en,
  input wire logic [PBG_WIDTH-1:0] sw_val,
  input wire logic [PBG_WIDTH-1:0] sw_en,
  output logic [PBG_WIDTH-1:0] pin_in
);
  // a floating pin wanders every cycle instead of holding its last level
  logic [PBG_WIDTH-1:0] float_pat = 8'h55;
  always_ff @(posedge pclk) begin
    float_pat <= ~float_pat;
  end
  always_comb begin
    for (int i = 0; i < PBG_WIDTH; i++) begin
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else if (sw_en[i]) pin_in[i] = sw_val[i];
      else if (pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_pat[i];
    end
  end
endmodule
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pbg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, pin_in, pin_out, pin_oe_n, pullup_en, sw_val, sw_en;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] lcd_seg_active, ext_irq_in;
  logic prog_serial_clock, prog_serial_data_in, prog_data_drive, prog_data_drive_en;
  logic port_change_irq, port_change_high_prio, wake_req;
  int miscompares = 0;
  int n_tests = 0;

  pbg_port pbg_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .lcd_seg_active(lcd_seg_active), .ext_irq_in(ext_irq_in),
    .prog_serial_clock(prog_serial_clock), .prog_serial_data_in(prog_serial_data_in),
    .prog_data_drive(prog_data_drive), .prog_data_drive_en(prog_data_drive_en),
    .port_change_irq(port_change_irq), .port_change_high_prio(port_change_high_prio),
    .wake_req(wake_req));
  pbg_pins_model pbg_pins_model_i (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pullup_en(pullup_en), .sw_val(sw_val), .sw_en(sw_en), .pin_in(pin_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic final_report();
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd[7:0], e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic sw(input logic [7:0] en, input logic [7:0] v);
    @(posedge pclk);
    sw_en <= en;
    sw_val <= v;
  endtask

  task automatic t_reset();
    settle(1);
    chk(pin_oe_n, 8'hFF); // inputs after reset
    chk(pullup_en, 8'h00); // pull-ups off
    rdc(PBG_ADDR_LATCH, PBG_RST_LATCH); // latch reset
    rdc(PBG_ADDR_DIR, PBG_RST_DIR); // direction reset
    rdc(PBG_ADDR_MAIN, PBG_RST_MAIN); // flag clear
    rdc(PBG_ADDR_EDGES, PBG_RST_EDGES); // pull-up bit set
    rdc(PBG_ADDR_EXT, PBG_RST_EXT);
    rdc(PBG_ADDR_SEG, PBG_RST_SEG); // segments off
    apb(1'b0, 8'h24, 8'h00);
    chk({7'h0, err}, 8'h01);
  endtask
  task automatic t_dir();
    wr(PBG_ADDR_LATCH, 8'hA5);
    wr(PBG_ADDR_DIR, 8'h0F);
    settle(1);
    chk(pin_oe_n, 8'h0F); // per-pin direction
    chk(pin_out & 8'hF0, 8'hA0); // latch on pins
    rdc(PBG_ADDR_LATCH, 8'hA5); // latch not pins
    wr(PBG_ADDR_PORT, 8'h5A);
    rdc(PBG_ADDR_LATCH, 8'h5A); // port write lands in latch
    wr(PBG_ADDR_LATCH, 8'hA5);
    settle(3);
    rdc(PBG_ADDR_PORT, 8'hAC); // mixed pins
  endtask
  task automatic t_pull();
    wr(PBG_ADDR_EDGES, 8'h7F);
    settle(1);
    chk(pullup_en, 8'h0F); // inputs only
    sw(8'hF0, 8'h00);
    settle(4);
    rdc(PBG_ADDR_PORT, 8'hAF); // pulled high
    wr(PBG_ADDR_EDGES, 8'hFF);
    settle(1);
    chk(pullup_en, 8'h00); // pull-ups off
  endtask
  task automatic t_chg();
    int k;
    wr(PBG_ADDR_DIR, 8'hFF);
    sw(8'hFF, 8'h00);
    settle(4);
    rdc(PBG_ADDR_PORT, 8'h00); // snapshot taken
    wr(PBG_ADDR_MAIN, 8'h08);
    settle(2);
    chk({7'h0, port_change_irq}, 8'h00); // no mismatch
    sw(8'hFF, 8'h20);
    for (k = 0; k < 8; k++) begin
      settle(1);
      if (port_change_irq === 1'b1) break;
    end
    chk({7'h0, port_change_irq}, 8'h01); // change seen
    chk({7'h0, wake_req}, 8'h01); // wake request
    wr(PBG_ADDR_MAIN, 8'h00);
    settle(2);
    chk({7'h0, port_change_irq}, 8'h00); // masked
    wr(PBG_ADDR_MAIN, 8'h08);
    settle(2);
    chk({7'h0, port_change_irq}, 8'h01); // flag kept set
    rdc(PBG_ADDR_PORT_QUIET, 8'h20); // quiet read
    wr(PBG_ADDR_MAIN, 8'h08);
    settle(2);
    chk({7'h0, port_change_irq}, 8'h01); // quiet read keeps mismatch
    rdc(PBG_ADDR_PORT, 8'h20); // refresh
    wr(PBG_ADDR_MAIN, 8'h08);
    rdc(PBG_ADDR_MAIN, 8'h08); // flag cleared
    sw(8'hFF, 8'h21);
    settle(6);
    chk({7'h0, port_change_irq}, 8'h00); // lower pin ignored
    wr(PBG_ADDR_DIR, 8'h7F);
    settle(6);
    chk({7'h0, port_change_irq}, 8'h00); // output pin excluded
    chk({7'h0, port_change_high_prio}, 8'h01); // priority set
    wr(PBG_ADDR_EDGES, 8'hFE);
    settle(1);
    chk({7'h0, port_change_high_prio}, 8'h00); // priority clear
  endtask
  task automatic t_seg();
    wr(PBG_ADDR_DIR, 8'h00);
    wr(PBG_ADDR_SEG, 8'h05);
    settle(1);
    chk(pin_oe_n, 8'h0A); // segment pins released
    chk({4'h0, lcd_seg_active}, 8'h05); // segment order
    wr(PBG_ADDR_SEG, 8'h00);
  endtask
  task automatic t_ext();
    wr(PBG_ADDR_DIR, 8'h05);
    sw(8'hFF, 8'h0F);
    settle(4);
    chk({4'h0, ext_irq_in}, 8'h05); // inputs only, in order
  endtask
  task automatic t_dbg();
    wr(PBG_ADDR_DIR, 8'hFF);
    sw(8'h7F, 8'h40);
    prog_data_drive <= 1'b1;
    prog_data_drive_en <= 1'b1;
    wr(PBG_ADDR_DEBUG, 8'h01);
    settle(4);
    chk({7'h0, prog_serial_clock}, 8'h01); // clock input
    chk({7'h0, pin_oe_n[7]}, 8'h00); // data driven
    chk({7'h0, pin_out[7]}, 8'h01); // data value
    chk({7'h0, prog_serial_data_in}, 8'h01); // data read back
    wr(PBG_ADDR_DEBUG, 8'h00);
    settle(1);
    chk({7'h0, pin_oe_n[7]}, 8'h01); // released
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sw_val = 8'h0C;
    sw_en = 8'hFF;
    prog_data_drive = 1'b0;
    prog_data_drive_en = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dir();
    t_pull();
    t_chg();
    t_seg();
    t_ext();
    t_dbg();
    final_report();
  end
endmodule
`default_nettype wire
